/* File: testbench/dpll_reference_selector_tb_top.sv */
`include "dpll_ref_sel_defs.svh"
`default_nettype none
module dpll_reference_selector_tb_top
   import dpll_ref_sel_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r; logic [7:0] a;} rexp_s;
   logic               i_clk = 0, i_rst_b = 0, sel_pin = 0, hist = 1;
   logic [1:0]         fail = 2'h3;
   logic signed [31:0] poff = 0, adj;
   logic [7:0]         awaddr = 0, araddr = 0, flags;
   logic [31:0]        wdata = 0, rdata;
   logic               awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic               ref_sel, awready, wready, bvalid, arready, rvalid;
   logic [1:0]         bresp, rresp;
   loop_state_e        loop_st;
   int                 num_errors = 0, n_checks = 0;
   rexp_s              rq[$];
   logic [1:0]         bq[$];
   rexp_s              e;
   logic [1:0]         eb;

   always #2.5 i_clk = ~i_clk;

   ref_flag_model ref_flag_model_i (.i_clk(i_clk), .i_fail(fail), .o_mon_flags(flags));

   dpll_reference_selector dpll_reference_selector_i (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_mon_flags(flags), .i_sel_pin(sel_pin),
      .i_history_valid(hist), .i_phase_offset(poff), .o_ref_sel(ref_sel),
      .o_loop_state(loop_st), .o_phase_adj(adj), .i_axi_awaddr(awaddr),
      .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_wdata(wdata),
      .i_axi_wstrb(4'hF), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
      .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
      .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
      .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
      .i_axi_rready(rready));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Results checked as they appear, against the oldest note
   always @(posedge i_clk) begin
      if (bvalid && bready && bq.size() > 0) begin
         eb = bq.pop_front();
         chk({30'h0, bresp}, {30'h0, eb});
      end
      if (rvalid && rready && rq.size() > 0) begin
         e = rq.pop_front();
         chk(rdata & e.m, e.d);
         chk({30'h0, rresp}, {30'h0, e.r});
         // Pins agree with the register word just read
         if (e.a == `ADDR_STATUS) chk({29'h0, loop_st, ref_sel}, {29'h0, rdata[2:0]});
         if (e.a == `ADDR_BUILDOUT) chk(adj, rdata);
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(aw_ok && w_ok)) begin
         @(posedge i_clk);
         if (awvalid && awready) begin aw_ok = 1; awvalid <= 0; end
         if (wvalid && wready) begin w_ok = 1; wvalid <= 0; end
      end
      do @(posedge i_clk); while (!bvalid);
      bready <= 0;
      @(posedge i_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] r);
      rq.push_back('{d, m, r, a});
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge i_clk); while (!arready);
      arvalid <= 0;
      do @(posedge i_clk); while (!rvalid);
      rready <= 0;
      @(posedge i_clk);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // Selected input and loop state; mask 6 ignores the selection
   task automatic st(input logic s, input loop_state_e l, input logic [31:0] m);
      settle(24);
      rd(`ADDR_STATUS, {29'h0, l, s} & m, m, `RESP_OKAY);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      // About 2200 cycles of tests; nine times that is a hang
      #100000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      void'($urandom(22));
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1;
      @(posedge i_clk);
      rd(`ADDR_CTRL, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
      rd(`ADDR_PRIO, 32'h21, 32'hFFFFFFFF, `RESP_OKAY);
      rd(`ADDR_VALTIME, 32'h100, 32'hFFFFFFFF, `RESP_OKAY);
      rd(`ADDR_SLEW, 32'h00640010, 32'hFFFFFFFF, `RESP_OKAY);
      rd(`ADDR_RDIV, 32'h00010001, 32'hFFFFFFFF, `RESP_OKAY);
      rd(8'h28, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
      wr(8'h2C, 32'hFFFFFFFF, `RESP_SLVERR);
      $display("registers done");
      wr(`ADDR_VALTIME, 32'h4, `RESP_OKAY);
      wr(`ADDR_MONEN, 32'hFF, `RESP_OKAY);
      fail <= 2'h0;
      settle(24);
      rd(`ADDR_STATUS, 32'h1A, 32'h1F, `RESP_OKAY);
      wr(`ADDR_PRIO, 32'h23, `RESP_OKAY);
      st(1, LOOP_TRACK, 32'h7);
      fail <= 2'h2;
      st(0, LOOP_TRACK, 32'h7);
      fail <= 2'h0;
      st(1, LOOP_TRACK, 32'h7);
      wr(`ADDR_PRIO, 32'h22, `RESP_OKAY);
      st(0, LOOP_TRACK, 32'h7);
      $display("auto revertive done");
      wr(`ADDR_CTRL, 32'h1, `RESP_OKAY);
      wr(`ADDR_PRIO, 32'h12, `RESP_OKAY);
      st(0, LOOP_TRACK, 32'h7);
      fail <= 2'h1;
      st(1, LOOP_TRACK, 32'h7);
      fail <= 2'h0;
      st(1, LOOP_TRACK, 32'h7);
      wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      hist <= 0;
      wr(`ADDR_PRIO, 32'h00, `RESP_OKAY);
      st(0, LOOP_FREERUN, 32'h6);
      hist <= 1;
      wr(`ADDR_PRIO, 32'h21, `RESP_OKAY);
      st(0, LOOP_TRACK, 32'h7);
      wr(`ADDR_PRIO, 32'h00, `RESP_OKAY);
      st(0, LOOP_HOLDOVER, 32'h6);
      wr(`ADDR_PRIO, 32'h21, `RESP_OKAY);
      $display("priority zero done");
      wr(`ADDR_CTRL, 32'h6, `RESP_OKAY);
      st(1, LOOP_TRACK, 32'h7);
      fail <= 2'h2;
      st(0, LOOP_TRACK, 32'h7);
      fail <= 2'h3;
      st(0, LOOP_HOLDOVER, 32'h6);
      fail <= 2'h0;
      wr(`ADDR_CTRL, 32'h7, `RESP_OKAY);
      st(1, LOOP_TRACK, 32'h7);
      fail <= 2'h2;
      st(1, LOOP_HOLDOVER, 32'h6);
      fail <= 2'h0;
      st(1, LOOP_TRACK, 32'h7);
      wr(`ADDR_CTRL, 32'hB, `RESP_OKAY);
      sel_pin <= 1;
      st(1, LOOP_TRACK, 32'h7);
      sel_pin <= 0;
      st(0, LOOP_TRACK, 32'h7);
      $display("manual done");
      poff <= {16'h0, 1'b1, 15'($urandom)};
      wr(`ADDR_CTRL, 32'h10, `RESP_OKAY);
      fail <= 2'h1;
      settle(24);
      rd(`ADDR_BUILDOUT, poff, 32'hFFFFFFFF, `RESP_OKAY);
      settle(600);
      rd(`ADDR_BUILDOUT, poff, 32'hFFFFFFFF, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      fail <= 2'h0;
      settle(24);
      rd(`ADDR_BUILDOUT, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
      // Step of 0x100 every 2 cycles: at most 256 steps
      wr(`ADDR_SLEW, 32'h00000100, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h30, `RESP_OKAY);
      fail <= 2'h1;
      settle(24);
      rd(`ADDR_STATUS, 32'h43, 32'h47, `RESP_OKAY);
      settle(800);
      rd(`ADDR_BUILDOUT, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h10, `RESP_OKAY);
      fail <= 2'h0;
      settle(24);
      rd(`ADDR_BUILDOUT, poff, 32'hFFFFFFFF, `RESP_OKAY);
      // loop already tracking before the 1-PPS switch
      wr(`ADDR_CTRL, 32'hD0, `RESP_OKAY);
      fail <= 2'h1;
      settle(24);
      rd(`ADDR_BUILDOUT, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
      // Product overflows 32 bits: must not read as locked
      wr(`ADDR_RDIV, 32'h00020001, `RESP_OKAY);
      wr(`ADDR_FREQ0, 32'h80000000, `RESP_OKAY);
      settle(2);
      rd(`ADDR_STATUS, 32'h0, 32'h20, `RESP_OKAY);
      wr(`ADDR_FREQ0, 32'h3, `RESP_OKAY);
      wr(`ADDR_FREQ1, 32'h6, `RESP_OKAY);
      settle(2);
      rd(`ADDR_STATUS, 32'h20, 32'h20, `RESP_OKAY);
      $display("hitless done");
      report_and_stop();
   end
endmodule
`default_nettype wire

/* File: testbench/ref_flag_model.sv */
`default_nettype none
module ref_flag_model (
   input  wire logic       i_clk,
   input  wire logic [1:0] i_fail,
   output var  logic [7:0] o_mon_flags
);
   timeunit 1ns;
   timeprecision 1ps;
   // one flag kind at a time; a wandering bit, not a steady one
   always @(posedge i_clk) begin
      o_mon_flags[3:0] <= i_fail[0] ? 4'h1 << $urandom_range(3) : 4'h0;
      o_mon_flags[7:4] <= i_fail[1] ? 4'h1 << $urandom_range(3) : 4'h0;
   end
endmodule
`default_nettype wire

/* File: verilog/dpll_ref_sel_defs.svh */
`ifndef DPLL_REF_SEL_DEFS_SVH
`define DPLL_REF_SEL_DEFS_SVH
`define ADDR_CTRL     8'h00
`define ADDR_PRIO     8'h04
`define ADDR_VALTIME  8'h08
`define ADDR_MONEN    8'h0C
`define ADDR_SLEW     8'h10
`define ADDR_FREQ0    8'h14
`define ADDR_FREQ1    8'h18
`define ADDR_RDIV     8'h1C
`define ADDR_STATUS   8'h20
`define ADDR_BUILDOUT 8'h24
`define CTRL_RST      8'h00
`define PRIO_RST      8'h21
`define VALTIME_RST   16'h0100
`define MONEN_RST     8'h00
`define SLEW_LIM_RST  16'h0010
`define SLEW_TMR_RST  16'h0064
`define FREQ_RST      32'h0000_0000
`define RDIV_RST      16'h0001
`define MON_PER_REF   4
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

/* File: verilog/dpll_ref_sel_pkg.sv */
`default_nettype none
package dpll_ref_sel_pkg;
   typedef enum logic [1:0] {
      MODE_AUTO_REVERT,
      MODE_AUTO_NONREV,
      MODE_MAN_FALLBACK,
      MODE_MAN_HOLDOVER
   } sel_mode_e;
   typedef enum logic [1:0] {
      LOOP_FREERUN,
      LOOP_TRACK,
      LOOP_HOLDOVER
   } loop_state_e;
   typedef struct packed {
      logic      pps_inputs;
      logic      zero_delay_sync;
      logic      phase_slew_enable;
      logic      phase_cancel_en;
      logic      sel_from_pins;
      logic      manual_reference_choice;
      sel_mode_e mode;
   } ctrl_s;
   typedef struct packed {
      logic       pad1;
      logic [2:0] prio1;
      logic       pad0;
      logic [2:0] prio0;
   } prio_s;
   typedef struct packed {
      logic [1:0]  usable;
      logic        slewing;
      logic        freq_locked;
      logic [1:0]  ref_valid;
      loop_state_e loop;
      logic        sel;
   } status_s;
endpackage
`default_nettype wire

/* File: verilog/dpll_reference_selector.sv */
// Overview of operation
// - Each input has priority 0..7; 0 never chosen automatically, 1 best.
// - Equal priorities favour reference_input_zero over reference_input_one.
// - Mux picks one of two inputs, automatically or manually.
// - Auto revertive always uses best valid input, switching immediately.
// - Auto non-revertive keeps current input until it turns invalid.
// - Manual modes take choice from register field or select pin.
// - Manual fallback keeps manual input until invalid, then best valid.
// - No valid prioritised input: holdover if history valid, else free-run.
// - Manual holdover mode enters holdover/free-run directly, no search.
// - Holdover ends when the selected input becomes valid again.
// - Selected input shown on status pin and status register.
// - Cancellation without slew keeps absorbed offset as permanent build-out.
// - Inputs frequency-locked when equal or dividing to common frequency.
// - Slew enable activates step limit and step timer.
// - With slew, cancelled offset is removed gradually by timed steps.
// - Slew also applies on acquisition exit and unlocked-input switches.
// - No cancellation and no slew: full offset passes to output.
// - 1-PPS hitless switching only with zero-delay sync disabled.
// - Gapped inputs accepted if gaps stay within one divided period.
// - Input valid only after enabled monitors clear for validation time.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`include "dpll_ref_sel_defs.svh"
`default_nettype none
module dpll_reference_selector
   import dpll_ref_sel_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic               i_rst_b,
   input  wire logic [7:0]         i_mon_flags,
   input  wire logic               i_sel_pin,
   input  wire logic               i_history_valid,
   input  wire logic signed [31:0] i_phase_offset,
   output var  logic               o_ref_sel,
   output var  loop_state_e        o_loop_state,
   output var  logic signed [31:0] o_phase_adj,
   input  wire logic [7:0]         i_axi_awaddr,
   input  wire logic               i_axi_awvalid,
   output var  logic               o_axi_awready,
   input  wire logic [31:0]        i_axi_wdata,
   input  wire logic [3:0]         i_axi_wstrb,
   input  wire logic               i_axi_wvalid,
   output var  logic               o_axi_wready,
   output var  logic [1:0]         o_axi_bresp,
   output var  logic               o_axi_bvalid,
   input  wire logic               i_axi_bready,
   input  wire logic [7:0]         i_axi_araddr,
   input  wire logic               i_axi_arvalid,
   output var  logic               o_axi_arready,
   output var  logic [31:0]        o_axi_rdata,
   output var  logic [1:0]         o_axi_rresp,
   output var  logic               o_axi_rvalid,
   input  wire logic               i_axi_rready
);
   ctrl_s        ctrl;
   prio_s        prio;
   logic [15:0]  valtime;
   logic [7:0]   mon_en;
   logic [15:0]  slew_limit;
   logic [15:0]  slew_timer;
   logic [31:0]  freq0;
   logic [31:0]  freq1;
   logic [15:0]  rdiv0;
   logic [15:0]  rdiv1;
   logic [7:0]   flag_meta;
   logic [7:0]   flag_sync;
   logic         pin_meta;
   logic         pin_sync;
   logic [1:0]   ref_valid;
   logic [1:0]   usable;
   logic         best;
   logic         has_best;
   logic         man;
   logic         next_sel;
   loop_state_e  next_loop;
   logic         switch_evt;
   logic         acq;
   logic         freq_locked;
   logic         hitless;
   logic         capture;
   logic         slewing;
   logic [15:0]  tmr_cnt;
   logic         tick;
   logic [31:0]  mag;
   logic [31:0]  lim_ext;
   logic [7:0]   waddr;
   logic [31:0]  wdata;
   logic [3:0]   wstrb;
   logic [31:0]  wmask;
   logic [31:0]  merged;
   status_s      status;

   // Monitor flags and select pin come from other domains
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flag_meta <= 8'h00;
         flag_sync <= 8'h00;
         pin_meta  <= 1'h0;
         pin_sync  <= 1'h0;
      end else begin
         flag_meta <= i_mon_flags;
         flag_sync <= flag_meta;
         pin_meta  <= i_sel_pin;
         pin_sync  <= pin_meta;
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_val
      logic [15:0] cnt;
      logic        hit;
      assign hit = |(flag_sync[g*`MON_PER_REF +: `MON_PER_REF]
                     & mon_en[g*`MON_PER_REF +: `MON_PER_REF]);
      // validation timer
      // Gap tolerance lives in the monitor windows, not here
      always_ff @(posedge i_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            cnt          <= 16'h0000;
            ref_valid[g] <= 1'h0;
         end else if (hit) begin
            cnt          <= 16'h0000;
            ref_valid[g] <= 1'h0;
         end else if (cnt >= valtime) begin
            ref_valid[g] <= 1'h1;
         end else begin
            cnt <= cnt + 16'h0001;
         end
      end
   end

   assign usable = {ref_valid[1] && (prio.prio1 != 3'h0),
                    ref_valid[0] && (prio.prio0 != 3'h0)};
   assign best = !(usable[0] && (!usable[1] || prio.prio0 <= prio.prio1));
   assign has_best = |usable;
   assign man = ctrl.sel_from_pins ? pin_sync : ctrl.manual_reference_choice;

   always_comb begin
      next_sel  = o_ref_sel;
      next_loop = i_history_valid ? LOOP_HOLDOVER : LOOP_FREERUN;
      case (ctrl.mode)
         MODE_AUTO_REVERT: begin
            if (has_best) begin
               next_sel  = best;
               next_loop = LOOP_TRACK;
            end
         end
         MODE_AUTO_NONREV: begin
            if (o_loop_state == LOOP_TRACK && usable[o_ref_sel]) begin
               next_loop = LOOP_TRACK;
            end else if (has_best) begin
               next_sel  = best;
               next_loop = LOOP_TRACK;
            end
         end
         MODE_MAN_FALLBACK: begin
            if (ref_valid[man]) begin
               next_sel  = man;
               next_loop = LOOP_TRACK;
            end else if (has_best) begin
               next_sel  = best;
               next_loop = LOOP_TRACK;
            end
         end
         MODE_MAN_HOLDOVER: begin
            next_sel = man;
            if (ref_valid[man]) begin
               next_loop = LOOP_TRACK;
            end
         end
         default: begin
            next_loop = o_loop_state;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_ref_sel    <= 1'h0;
         o_loop_state <= LOOP_FREERUN;
      end else begin
         o_ref_sel    <= next_sel;
         o_loop_state <= next_loop;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         freq_locked <= 1'h0;
      end else begin
         // Full 48-bit products: a 32-bit compare would wrap and fake a lock
         freq_locked <= (48'(freq0) * 48'(rdiv1)) == (48'(freq1) * 48'(rdiv0));
      end
   end

   assign acq = o_loop_state != LOOP_TRACK;
   assign switch_evt = next_loop == LOOP_TRACK && (acq || next_sel != o_ref_sel);
   // no hitless 1-PPS under zero-delay sync
   assign hitless = ctrl.phase_cancel_en && !(ctrl.pps_inputs && ctrl.zero_delay_sync);
   // slew on acquisition and unlocked switch
   assign capture = (hitless && freq_locked && !acq)
                    || (ctrl.phase_slew_enable && (acq || !freq_locked));
   assign mag = o_phase_adj[31] ? 32'(-o_phase_adj) : 32'(o_phase_adj);
   assign lim_ext = 32'(slew_limit);

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tmr_cnt <= 16'h0000;
         tick    <= 1'h0;
      end else if (!slewing || tick) begin
         tmr_cnt <= 16'h0000;
         tick    <= 1'h0;
      end else if (tmr_cnt >= slew_timer) begin
         tmr_cnt <= 16'h0000;
         tick    <= 1'h1;
      end else begin
         tmr_cnt <= tmr_cnt + 16'h0001;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_phase_adj <= 32'sh0000_0000;
         slewing     <= 1'h0;
      end else if (switch_evt) begin
         if (capture) begin
            o_phase_adj <= i_phase_offset;
            slewing     <= ctrl.phase_slew_enable;
         end else begin
            o_phase_adj <= 32'sh0000_0000;
            slewing     <= 1'h0;
         end
      end else if (!ctrl.phase_slew_enable) begin
         slewing <= 1'h0;
      end else if (slewing && tick) begin
         if (mag <= lim_ext) begin
            o_phase_adj <= 32'sh0000_0000;
            slewing     <= 1'h0;
         end else if (o_phase_adj[31]) begin
            o_phase_adj <= o_phase_adj + $signed(lim_ext);
         end else begin
            o_phase_adj <= o_phase_adj - $signed(lim_ext);
         end
      end
   end

   assign status = '{usable: usable, slewing: slewing, freq_locked: freq_locked,
                     ref_valid: ref_valid, loop: o_loop_state, sel: o_ref_sel};

   function automatic logic [31:0] rd_word(input logic [7:0] a);
      case ({a[7:2], 2'h0})
         `ADDR_CTRL:     rd_word = 32'(ctrl);
         `ADDR_PRIO:     rd_word = 32'(prio);
         `ADDR_VALTIME:  rd_word = 32'(valtime);
         `ADDR_MONEN:    rd_word = 32'(mon_en);
         `ADDR_SLEW:     rd_word = {slew_timer, slew_limit};
         `ADDR_FREQ0:    rd_word = freq0;
         `ADDR_FREQ1:    rd_word = freq1;
         `ADDR_RDIV:     rd_word = {rdiv1, rdiv0};
         `ADDR_STATUS:   rd_word = 32'(status);
         `ADDR_BUILDOUT: rd_word = o_phase_adj;
         default:        rd_word = 32'h0000_0000;
      endcase
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = {a[7:2], 2'h0} <= `ADDR_BUILDOUT;
   endfunction

   // Write channels captured in either order
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_axi_awready <= 1'h1;
         o_axi_wready  <= 1'h1;
         o_axi_bvalid  <= 1'h0;
         o_axi_bresp   <= `RESP_OKAY;
         waddr         <= 8'h00;
         wdata         <= 32'h0000_0000;
         wstrb         <= 4'h0;
      end else begin
         if (i_axi_awvalid && o_axi_awready) begin
            o_axi_awready <= 1'h0;
            waddr         <= i_axi_awaddr;
         end
         if (i_axi_wvalid && o_axi_wready) begin
            o_axi_wready <= 1'h0;
            wdata        <= i_axi_wdata;
            wstrb        <= i_axi_wstrb;
         end
         if (!o_axi_awready && !o_axi_wready && !o_axi_bvalid) begin
            o_axi_bvalid <= 1'h1;
            o_axi_bresp  <= mapped(waddr) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (o_axi_bvalid && i_axi_bready) begin
            o_axi_bvalid  <= 1'h0;
            o_axi_awready <= 1'h1;
            o_axi_wready  <= 1'h1;
         end
      end
   end

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{wstrb[b]}};
      end
      merged = (rd_word(waddr) & ~wmask) | (wdata & wmask);
   end

   // Write lands in the cycle bvalid rises
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl       <= `CTRL_RST;
         prio       <= `PRIO_RST;
         valtime    <= `VALTIME_RST;
         mon_en     <= `MONEN_RST;
         slew_limit <= `SLEW_LIM_RST;
         slew_timer <= `SLEW_TMR_RST;
         freq0      <= `FREQ_RST;
         freq1      <= `FREQ_RST;
         rdiv0      <= `RDIV_RST;
         rdiv1      <= `RDIV_RST;
      end else if (!o_axi_awready && !o_axi_wready && !o_axi_bvalid) begin
         case ({waddr[7:2], 2'h0})
            `ADDR_CTRL:    ctrl    <= ctrl_s'(merged[7:0]);
            `ADDR_PRIO:    prio    <= prio_s'(merged[7:0]);
            `ADDR_VALTIME: valtime <= merged[15:0];
            `ADDR_MONEN:   mon_en  <= merged[7:0];
            `ADDR_SLEW: begin
               slew_limit <= merged[15:0];
               slew_timer <= merged[31:16];
            end
            `ADDR_FREQ0:   freq0   <= merged;
            `ADDR_FREQ1:   freq1   <= merged;
            `ADDR_RDIV: begin
               rdiv0 <= merged[15:0];
               rdiv1 <= merged[31:16];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_axi_arready <= 1'h1;
         o_axi_rvalid  <= 1'h0;
         o_axi_rdata   <= 32'h0000_0000;
         o_axi_rresp   <= `RESP_OKAY;
      end else if (i_axi_arvalid && o_axi_arready) begin
         o_axi_arready <= 1'h0;
         o_axi_rvalid  <= 1'h1;
         o_axi_rdata   <= rd_word(i_axi_araddr);
         o_axi_rresp   <= mapped(i_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (o_axi_rvalid && i_axi_rready) begin
         o_axi_rvalid  <= 1'h0;
         o_axi_arready <= 1'h1;
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);

   property p_revert_best;
      ctrl.mode == MODE_AUTO_REVERT && has_best
      |=> o_ref_sel == $past(best) && o_loop_state == LOOP_TRACK;
   endproperty
   a_revert_best: assert property (p_revert_best)
      else $error("revertive mode did not take best input");

   property p_tie_low;
      ctrl.mode == MODE_AUTO_REVERT && usable == 2'h3 && prio.prio0 == prio.prio1
      |=> !o_ref_sel;
   endproperty
   a_tie_low: assert property (p_tie_low)
      else $error("equal priority did not pick input zero");

   property p_nonrev_hold;
      ctrl.mode == MODE_AUTO_NONREV && o_loop_state == LOOP_TRACK && usable[o_ref_sel]
      |=> $stable(o_ref_sel) && o_loop_state == LOOP_TRACK;
   endproperty
   a_nonrev_hold: assert property (p_nonrev_hold)
      else $error("non-revertive mode left a usable input");

   property p_man_hold;
      ctrl.mode == MODE_MAN_FALLBACK && ref_valid[man]
      |=> o_ref_sel == $past(man) && o_loop_state == LOOP_TRACK;
   endproperty
   a_man_hold: assert property (p_man_hold)
      else $error("manual input not kept while valid");

   property p_fallback_none;
      ctrl.mode == MODE_MAN_FALLBACK && !ref_valid[man] && !has_best
      |=> o_loop_state == ($past(i_history_valid) ? LOOP_HOLDOVER : LOOP_FREERUN);
   endproperty
   a_fallback_none: assert property (p_fallback_none)
      else $error("fallback without input took wrong loop state");

   property p_man_holdover;
      ctrl.mode == MODE_MAN_HOLDOVER && !ref_valid[man] && has_best
      |=> o_loop_state != LOOP_TRACK;
   endproperty
   a_man_holdover: assert property (p_man_holdover)
      else $error("manual holdover mode searched for another input");

   property p_invalid_flag;
      |(flag_sync[3:0] & mon_en[3:0]) |=> !ref_valid[0] ##1 !ref_valid[0] || valtime == 16'h0000;
   endproperty
   a_invalid_flag: assert property (p_invalid_flag)
      else $error("input valid despite monitor flag");

   property p_no_hit_cancel;
      switch_evt && !ctrl.phase_cancel_en && !ctrl.phase_slew_enable
      |=> o_phase_adj == 32'sh0000_0000;
   endproperty
   a_no_hit_cancel: assert property (p_no_hit_cancel)
      else $error("offset absorbed with cancel and slew off");

   property p_buildout_kept;
      !switch_evt && !ctrl.phase_slew_enable |=> $stable(o_phase_adj);
   endproperty
   a_buildout_kept: assert property (p_buildout_kept)
      else $error("build-out changed without slew");

   property p_slew_step;
      slewing && tick && ctrl.phase_slew_enable && !switch_evt && mag > lim_ext
      |=> mag == $past(mag) - $past(lim_ext);
   endproperty
   a_slew_step: assert property (p_slew_step)
      else $error("slew step size wrong");
endmodule
`default_nettype wire
